/* File: rtl/afe_ctrl_pkg.sv */
package afe_ctrl_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_TXLVL  = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQST  = 8'h0C;
    localparam logic [7:0] OFF_IRQMSK = 8'h10;
    // control fields
    localparam int CTRL_AGC_EN_BIT = 0;
    localparam int CTRL_PSK_BIT    = 1;
    // status fields
    localparam int ST_GAIN_LSB  = 0;
    localparam int ST_TXLVL_LSB = 4;
    localparam int ST_ZONE_LSB  = 12;
    localparam int ST_PA_OFF    = 16;
    localparam int ST_READY     = 17;
    // interrupt bits
    localparam int IRQ_SHUTDOWN = 0;
    localparam int IRQ_ZONE     = 1;
    localparam int IRQ_CLIMIT   = 2;
    localparam int IRQ_READY    = 3;
    localparam int IRQ_W        = 4;
    // codes
    localparam logic [3:0] GAIN_MAX   = 4'h8;
    localparam logic [3:0] GAIN_RESET = 4'h3;
    localparam logic [4:0] TXLVL_MAX  = 5'h1F;
    localparam logic [4:0] TXLVL_RST  = 5'h1F;
    // timing
    localparam int CLK_HZ         = 20_000_000;
    localparam int STARTUP_MS     = 60;
    localparam int STARTUP_CYC    = STARTUP_MS * (CLK_HZ / 1000);
    localparam int RESET_PULSE_US = 1;
    localparam int RESET_PULSE_CYC = RESET_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int STEP_US        = 10;
    localparam int STEP_CYC       = STEP_US * (CLK_HZ / 1_000_000);
    // internal clock rates
    localparam int FRONT_END_HZ = 8_000_000;
    localparam int PROTOCOL_HZ  = 28_000_000;
    localparam int PHY_CORE_HZ  = 56_000_000;
endpackage

/* File: rtl/afe_step_timer.sv */
// free running tick used to pace the gain and level loops
module afe_step_timer #(
    parameter int PERIOD = 200
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    output logic      tick_o
);
    logic [15:0] count;
    wire last = (count == 16'(PERIOD - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count  <= 16'h0000;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            count  <= last ? 16'h0000 : count + 16'h0001;
            tick_o <= last;
        end
    end
endmodule

/* File: rtl/afe_gain_thermal_control.sv */
// Behaviour
// - the receive gain code runs 0 to 8, -18 dB plus 6 dB per code.
// - an automatic loop raises or lowers the gain code to keep the input in converter range.
// - the transmit level code has 32 logarithmic steps from 0 dB down to -31 dB.
// - attenuation in dB equals 31 minus the transmit level code.
// - while current sense is above threshold the transmit level drops one step at a time.
// - limit resistor select is driven low for FSK and released for PSK.
// - the amplifier shuts down above threshold 4 and returns only below threshold 3.
// - the temperature zone reads 1 to 4 from thresholds 1, 2 and 3.
// - the block is not ready until the start-up interval after reset has passed.
// - internal clocks are 8, 28 and 56 MHz for front end, protocol and phy core.
module afe_gain_thermal_control
    import afe_ctrl_pkg::*;
#(
    parameter int STARTUP_CYCLES = afe_ctrl_pkg::STARTUP_CYC,
    parameter int STEP_CYCLES    = afe_ctrl_pkg::STEP_CYC
) (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // analog front end
    input  wire logic        reset_input_low_i,
    input  wire logic        adc_over_i,
    input  wire logic        adc_under_i,
    input  wire logic        current_sense_over_i,
    input  wire logic [3:0]  temp_threshold_i,
    output logic      [3:0]  rx_gain_o,
    output logic      [4:0]  tx_level_o,
    output logic             amplifier_output_en_o,
    output logic             limit_resistor_select_o,
    output logic             limit_resistor_select_oe_n_o,
    output logic             ready_o,
    output logic             irq_o
);
    import afe_ctrl_pkg::*;

    logic [1:0]        ctrl;
    logic [4:0]        tx_set;
    logic [3:0]        gain;
    logic [4:0]        level;
    logic              pa_off;
    logic [1:0]        zone;
    logic [1:0]        zone_q;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  irq_msk;
    logic [23:0]       boot_cnt;
    logic              ready;
    logic              ready_q;
    logic [7:0]        rst_pulse;
    logic              ext_reset;
    logic              tick;

    // any bus write lands only with lane 0 enabled; narrow registers
    wire bus_req   = cyc_i & stb_i & ~ack_o & ce_i;
    wire wr        = bus_req & we_i & sel_i[0];
    wire rd        = bus_req & ~we_i;
    wire hit_ctrl  = (adr_i == OFF_CTRL);
    wire hit_tx    = (adr_i == OFF_TXLVL);
    wire hit_st    = (adr_i == OFF_STATUS);
    wire hit_irq   = (adr_i == OFF_IRQST);
    wire hit_msk   = (adr_i == OFF_IRQMSK);
    wire psk_mode  = ctrl[CTRL_PSK_BIT];
    wire agc_en    = ctrl[CTRL_AGC_EN_BIT];

    afe_step_timer #(.PERIOD(STEP_CYCLES)) u_step (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .tick_o (tick)
    );

    // pulse qualifier
    // a low pulse shorter than the minimum is ignored as a glitch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_pulse <= 8'h00;
            ext_reset <= 1'b0;
        end else if (ce_i) begin
            rst_pulse <= reset_input_low_i ? 8'h00 :
                         (rst_pulse == 8'hFF ? rst_pulse : rst_pulse + 8'h01);
            ext_reset <= ~reset_input_low_i && (rst_pulse >= 8'(RESET_PULSE_CYC - 1));
        end
    end

    wire boot_done = (boot_cnt >= 24'(STARTUP_CYCLES - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_cnt <= 24'h000000;
            ready    <= 1'b0;
        end else if (ce_i) begin
            if (ext_reset) begin
                boot_cnt <= 24'h000000;
                ready    <= 1'b0;
            end else if (!ready) begin
                boot_cnt <= boot_cnt + 24'h000001;
                ready    <= boot_done;
            end
        end
    end

    wire gain_up   = agc_en & ready & tick & adc_under_i & ~adc_over_i & (gain != GAIN_MAX);
    wire gain_down = agc_en & ready & tick & adc_over_i & (gain != 4'h0);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gain <= GAIN_RESET;
        end else if (ce_i) begin
            // pin reset waits for the enable too, so a frozen block stays frozen
            if (ext_reset) begin
                gain <= GAIN_RESET;
            end else if (gain_down) begin
                gain <= gain - 4'h1;
            end else if (gain_up) begin
                gain <= gain + 4'h1;
            end
        end
    end

    // floor at zero
    // software level is the ceiling; the loop never raises above it
    wire cl_step = ready & tick & current_sense_over_i & (level != 5'h00);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level <= TXLVL_RST;
        end else if (ce_i) begin
            if (ext_reset) begin
                level <= TXLVL_RST;
            end else if (wr && hit_tx) begin
                level <= dat_i[4:0];
            end else if (cl_step) begin
                level <= level - 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_off <= 1'b0;
        end else if (ce_i) begin
            if (temp_threshold_i[3]) begin
                pa_off <= 1'b1;
            end else if (!temp_threshold_i[2]) begin
                pa_off <= 1'b0;
            end
        end
    end

    // zone code, stored as zone minus one
    always_comb begin
        if (temp_threshold_i[2]) begin
            zone = 2'd3;
        end else if (temp_threshold_i[1]) begin
            zone = 2'd2;
        end else if (temp_threshold_i[0]) begin
            zone = 2'd1;
        end else begin
            zone = 2'd0;
        end
    end

    wire [31:0] status_word = {14'h0000, ready, pa_off, 2'b00, zone, 3'b000, level, gain};
    wire [31:0] rd_data = hit_ctrl ? {30'h0, ctrl} :
                          hit_tx   ? {27'h0, tx_set} :
                          hit_st   ? status_word :
                          hit_irq  ? {28'h0, irq_st} :
                          hit_msk  ? {28'h0, irq_msk} : 32'h00000000;

    // registers and events; a set in the read cycle wins over the clear
    wire [IRQ_W-1:0] ev;
    assign ev[IRQ_SHUTDOWN] = temp_threshold_i[3] & ~pa_off;
    assign ev[IRQ_ZONE]     = (zone != zone_q);
    assign ev[IRQ_CLIMIT]   = cl_step;
    assign ev[IRQ_READY]    = ready & ~ready_q;
    wire irq_clr = rd & hit_irq;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl    <= 2'b01;
            tx_set  <= TXLVL_RST;
            irq_st  <= '0;
            irq_msk <= '0;
            zone_q  <= 2'd0;
            ready_q <= 1'b0;
            ack_o   <= 1'b0;
            dat_o   <= 32'h00000000;
        end else if (ce_i) begin
            zone_q  <= zone;
            ready_q <= ready;
            ack_o   <= bus_req;
            irq_st  <= (irq_clr ? '0 : irq_st) | ev;
            if (wr && hit_ctrl) ctrl <= dat_i[1:0];
            if (wr && hit_tx) tx_set <= dat_i[4:0];
            if (wr && hit_msk) irq_msk <= dat_i[IRQ_W-1:0];
            if (rd) dat_o <= rd_data;
        end
    end

    assign tx_level_o  = level;
    assign rx_gain_o   = gain;
    assign amplifier_output_en_o = ~pa_off & ready;
    assign limit_resistor_select_o      = 1'b0;
    assign limit_resistor_select_oe_n_o = psk_mode;
    // clocks are generated by the pll outside this logic
    assign ready_o = ready;
    assign irq_o   = |(irq_st & irq_msk);

    property p_gain_range;
        @(posedge clk_i) disable iff (rst_i) gain <= GAIN_MAX;
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain out of range");

    property p_agc_up;
        @(posedge clk_i) disable iff (rst_i) (ce_i && gain_up && !gain_down && !ext_reset)
            |=> gain == $past(gain) + 4'h1;
    endproperty
    a_agc_up: assert property (p_agc_up) else $error("agc did not raise gain");

    property p_agc_down;
        @(posedge clk_i) disable iff (rst_i) (ce_i && gain_down && !ext_reset)
            |=> gain == $past(gain) - 4'h1;
    endproperty
    a_agc_down: assert property (p_agc_down) else $error("agc did not lower gain");

    property p_level_range;
        @(posedge clk_i) disable iff (rst_i) (ce_i && !ext_reset && !(wr && hit_tx))
            |=> tx_level_o <= $past(tx_level_o);
    endproperty
    a_level_range: assert property (p_level_range) else $error("level out of range");

    property p_level_reset;
        @(posedge clk_i) $fell(rst_i) |-> tx_level_o == 5'h1F;
    endproperty
    a_level_reset: assert property (p_level_reset) else $error("level not full scale");

    property p_climit;
        @(posedge clk_i) disable iff (rst_i || ext_reset)
            (ce_i && cl_step && !(wr && hit_tx)) |=> tx_level_o == $past(tx_level_o) - 5'h01;
    endproperty
    a_climit: assert property (p_climit) else $error("current limit missed a step");

    property p_cl_hold;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && !current_sense_over_i && !ext_reset && !(wr && hit_tx)) |=> level == $past(level);
    endproperty
    a_cl_hold: assert property (p_cl_hold) else $error("level moved without overcurrent");

    property p_cl_floor;
        @(posedge clk_i) disable iff (rst_i)
            (level == 5'h00 && !ext_reset && !(wr && hit_tx)) |=> level == 5'h00;
    endproperty
    a_cl_floor: assert property (p_cl_floor) else $error("level wrapped below zero");

    property p_sel;
        @(posedge clk_i) disable iff (rst_i)
            limit_resistor_select_oe_n_o == ctrl[CTRL_PSK_BIT] && !limit_resistor_select_o;
    endproperty
    a_sel: assert property (p_sel) else $error("limit resistor select wrong");

    property p_thermal;
        @(posedge clk_i) disable iff (rst_i) (ce_i && temp_threshold_i[3])
            |=> !amplifier_output_en_o;
    endproperty
    a_thermal: assert property (p_thermal) else $error("amplifier not shut down");

    property p_thermal_hold;
        @(posedge clk_i) disable iff (rst_i) (ce_i && pa_off && temp_threshold_i[2]) |=> pa_off;
    endproperty
    a_thermal_hold: assert property (p_thermal_hold) else $error("amplifier back too early");

    property p_zone;
        @(posedge clk_i) disable iff (rst_i)
            (temp_threshold_i == 4'h3) |-> zone == 2'd2;
    endproperty
    a_zone: assert property (p_zone) else $error("zone code wrong");

    property p_ready;
        @(posedge clk_i) disable iff (rst_i) (!ready && boot_cnt == 24'h000000) |=> !ready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready too early");

    property p_ready_time;
        @(posedge clk_i) disable iff (rst_i) $rose(ready) |-> boot_cnt == 24'(STARTUP_CYCLES);
    endproperty
    a_ready_time: assert property (p_ready_time) else $error("start-up interval wrong");
endmodule

/* File: verif/afe_line_model.sv */
// analog side: converter range, current sense, temperature sensor, reset pin
module afe_line_model
    import afe_ctrl_pkg::*;
(
    // bench controls
    input  wire logic       clk_i,
    input  wire logic [7:0] temp_c_i,
    input  wire logic [3:0] fit_i,
    input  wire logic [5:0] lim_i,
    input  wire logic       rst_pulse_i,
    // block outputs seen by the analog side
    input  wire logic [3:0] rx_gain_i,
    input  wire logic [4:0] tx_level_i,
    // analog indications
    output logic            reset_input_low_o,
    output logic            adc_over_o,
    output logic            adc_under_o,
    output logic            current_sense_over_o,
    output logic [3:0]      temp_threshold_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned low_cnt = 0;

    // pin held low for the minimum pulse
    always @(posedge clk_i) begin
        if (rst_pulse_i) begin
            low_cnt <= RESET_PULSE_CYC;
        end else if (low_cnt != 0) begin
            low_cnt <= low_cnt - 1;
        end
    end
    assign reset_input_low_o = (low_cnt == 0);
    // range flags follow gain against the signal size
    assign adc_over_o  = rx_gain_i > fit_i;
    assign adc_under_o = rx_gain_i < fit_i;
    // sense current grows with level; lim 0 means a short that never clears
    assign current_sense_over_o = {1'b0, tx_level_i} >= lim_i;
    assign temp_threshold_o = {temp_c_i > 8'hAA, temp_c_i > 8'h7D,
                               temp_c_i > 8'h64, temp_c_i > 8'h46};
endmodule

/* File: verif/tb_afe_gain_thermal_control.sv */
module tb_afe_gain_thermal_control;
    timeunit 1ns;
    timeprecision 1ns;
    import afe_ctrl_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, irq_o, ready_o;
    logic [7:0] adr_i = 8'h00, temp_c = 8'h14;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [3:0] rx_gain_o, temp_threshold_i, fit = 4'h3, sel_i = 4'h0;
    logic [4:0] tx_level_o;
    logic [5:0] lim = 6'h20;
    logic rst_pulse = 0, reset_input_low_i, adc_over_i, adc_under_i, current_sense_over_i;
    logic amplifier_output_en_o, limit_resistor_select_o, limit_resistor_select_oe_n_o, a;
    int n_errors = 0, compares = 0;
    logic [7:0] temps [5] = '{8'h14, 8'h50, 8'h6E, 8'h82, 8'hB4};

    always #25 clk_i = ~clk_i;

    afe_gain_thermal_control #(.STARTUP_CYCLES(50), .STEP_CYCLES(4)) i_dut (
        .clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .reset_input_low_i, .adc_over_i, .adc_under_i, .current_sense_over_i,
        .temp_threshold_i, .rx_gain_o, .tx_level_o, .amplifier_output_en_o,
        .limit_resistor_select_o, .limit_resistor_select_oe_n_o, .ready_o, .irq_o);

    afe_line_model i_line (
        .clk_i, .temp_c_i(temp_c), .fit_i(fit), .lim_i(lim), .rst_pulse_i(rst_pulse),
        .rx_gain_i(rx_gain_o), .tx_level_i(tx_level_o), .reset_input_low_o(reset_input_low_i),
        .adc_over_o(adc_over_i), .adc_under_o(adc_under_i),
        .current_sense_over_o(current_sense_over_i), .temp_threshold_o(temp_threshold_i));

    task automatic test_done();
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; ack sampled at the edge, request dropped after it
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'hF;
        adr_i <= ad;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        if (n >= 20) begin
            chk(1, 0);
            test_done();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_ready();
        int n;
        for (n = 0; n < 200 && ready_o !== 1'b1; n++) begin
            @(posedge clk_i);
        end
        // ready comes after the start-up interval
        chk(ready_o, 1);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({ready_o, rx_gain_o, tx_level_o}, {1'b0, GAIN_RESET, TXLVL_RST});
        wait_ready();
        wb(0, OFF_CTRL, 0);
        chk(q, 32'h1);
        wb(0, 8'hFC, 0);
        chk(q, 32'h0);
        wb(0, OFF_IRQST, 0);
        chk(q[IRQ_READY], 1);
        chk(irq_o, 0);
        fit <= 4'hF;
        repeat (100) @(posedge clk_i);
        chk(rx_gain_o, GAIN_MAX);
        fit <= 4'h0;
        repeat (100) @(posedge clk_i);
        wb(0, OFF_STATUS, 0);
        chk(q[3:0], 0);
        lim <= 6'h15;
        wb(1, OFF_TXLVL, 32'h1F);
        repeat (200) @(posedge clk_i);
        chk(tx_level_o, 5'h14);
        lim <= 6'h20;
        wb(1, OFF_TXLVL, 32'h05);
        wb(0, OFF_STATUS, 0);
        chk(q[8:4], 5'h05);
        lim <= 6'h00;
        repeat (100) @(posedge clk_i);
        chk(tx_level_o, 0);
        wb(0, OFF_IRQST, 0);
        chk(q[IRQ_CLIMIT], 1);
        lim <= 6'h20;
        wb(1, OFF_CTRL, 32'h3);
        chk(limit_resistor_select_oe_n_o, 1);
        wb(1, OFF_CTRL, 32'h1);
        chk({limit_resistor_select_o, limit_resistor_select_oe_n_o}, 0);
        for (int i = 0; i < 5; i++) begin
            temp_c <= temps[i];
            repeat (4) @(posedge clk_i);
            wb(0, OFF_STATUS, 0);
            chk(q[13:12], (i > 3) ? 3 : i);
            chk({q[16], amplifier_output_en_o}, (i > 3) ? 2'b10 : 2'b01);
        end
        temp_c <= 8'h82;
        repeat (4) @(posedge clk_i);
        chk(amplifier_output_en_o, 0);
        temp_c <= 8'h78;
        repeat (4) @(posedge clk_i);
        chk(amplifier_output_en_o, 1);
        wb(1, OFF_IRQMSK, 32'h0);
        a = irq_o;
        wb(1, OFF_IRQMSK, 32'hF);
        chk(a ^ irq_o, 1);
        wb(0, OFF_IRQST, 0);
        chk(q[IRQ_SHUTDOWN], 1);
        @(posedge clk_i);
        chk(irq_o, 0);
        rst_pulse <= 1'b1;
        @(posedge clk_i);
        rst_pulse <= 1'b0;
        repeat (25) @(posedge clk_i);
        chk({ready_o, rx_gain_o, tx_level_o}, {1'b0, GAIN_RESET, TXLVL_RST});
        wait_ready();
        test_done();
    end
endmodule
